// ===== logic/qbp_consts.svh
`ifndef QBP_CONSTS_SVH
`define QBP_CONSTS_SVH

// Port width and latch reset value
`define QBP_WIDTH         8
`define QBP_LATCH_RST     8'hff
`define QBP_ZERO          8'h00

// Strong high transition driver on-time
`define QBP_KICK_NS       16
`define QBP_CLK_NS        8
`define QBP_KICK_CYC      ((`QBP_KICK_NS + `QBP_CLK_NS - 1) / `QBP_CLK_NS)

// Second port alternate function bit positions
`define QBP_B_T2_IO       0
`define QBP_B_T2_TRIG     1
`define QBP_B_SER_RX      2
`define QBP_B_SER_TX      3
`define QBP_B_IRQ_RISE_A  4
`define QBP_B_IRQ_FALL_A  5
`define QBP_B_IRQ_RISE_B  6
`define QBP_B_IRQ_FALL_B  7

`endif

// ===== logic/qbp_pkg.sv
package qbp_pkg;

    typedef logic [7:0] qbp_byte_t;

    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] kick;
        logic [1:0] cnt;
    } qbp_pin_state_t;

endpackage

// ===== logic/qbp_quasi_port.sv
`timescale 1ns/1ps
`include "qbp_consts.svh"

// One 8-bit quasi-bidirectional port: latch, strong pulldown, momentary kick
module qbp_quasi_port
    import qbp_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    // Software latch write
    input  wire logic       wr_en,
    input  wire qbp_byte_t  wr_data,
    // Alternate function override per bit
    input  wire qbp_byte_t  alt_en,
    input  wire qbp_byte_t  alt_val,
    // Pin drive
    output qbp_byte_t       latch,
    output qbp_byte_t       pull_low,
    output qbp_byte_t       kick_high,
    output qbp_byte_t       weak_up
);

    qbp_pin_state_t s_q;
    qbp_pin_state_t s_d;
    qbp_byte_t      lvl_q;
    qbp_byte_t      lvl_d;

    assign latch = s_q.latch;

    always_comb
    begin
        s_d = s_q;
        if (wr_en)
        begin
            s_d.latch = wr_data;
        end
        // Effective level: latch or alternate value
        lvl_d = (s_d.latch & ~alt_en) | (alt_val & alt_en);
        // Rising level arms the strong driver for a fixed time
        if ((lvl_d & ~lvl_q) != `QBP_ZERO)
        begin
            s_d.kick = s_d.kick | (lvl_d & ~lvl_q);
            s_d.cnt  = 2'(`QBP_KICK_CYC);
        end
        else if (s_q.cnt != 2'h0)
        begin
            s_d.cnt = s_q.cnt - 2'h1;
            if (s_q.cnt == 2'h1)
            begin
                s_d.kick = `QBP_ZERO;
            end
        end
        s_d.kick = s_d.kick & lvl_d;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q       <= '{latch: `QBP_LATCH_RST, kick: `QBP_ZERO, cnt: 2'h0};
            lvl_q     <= `QBP_LATCH_RST;
            pull_low  <= `QBP_ZERO;
            kick_high <= `QBP_ZERO;
            weak_up   <= `QBP_LATCH_RST;
        end
        else
        begin
            s_q       <= s_d;
            lvl_q     <= lvl_d;
            pull_low  <= ~lvl_d;
            kick_high <= s_d.kick;
            weak_up   <= lvl_d;
        end
    end

endmodule // qbp_quasi_port

// ===== logic/qbp_ports.sv
`timescale 1ns/1ps
`include "qbp_consts.svh"

module qbp_ports
    import qbp_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    // Latch writes from the core
    input  wire logic       p0_wr,
    input  wire logic       p1_wr,
    input  wire logic       p2_wr,
    input  wire qbp_byte_t  wr_data,
    // External bus control from the core
    input  wire logic       bus_active,
    input  wire logic       bus_addr_phase,
    input  wire logic       bus_data_drive,
    input  wire qbp_byte_t  bus_addr_lo,
    input  wire qbp_byte_t  bus_data_out,
    input  wire qbp_byte_t  upper_address_byte,
    // Alternate outputs from peripherals
    input  wire logic       timer2_out_en,
    input  wire logic       timer2_out,
    input  wire logic       serial1_transmit_en,
    input  wire logic       serial1_transmit_out,
    // Pins: input, output, output enable
    input  wire qbp_byte_t  p0_pin_in,
    output qbp_byte_t       p0_pin_out,
    output qbp_byte_t       p0_pin_oe,
    input  wire qbp_byte_t  p1_pin_in,
    output qbp_byte_t       p1_pin_out,
    output qbp_byte_t       p1_pin_oe,
    output qbp_byte_t       p1_weak_up,
    input  wire qbp_byte_t  p2_pin_in,
    output qbp_byte_t       p2_pin_out,
    output qbp_byte_t       p2_pin_oe,
    output qbp_byte_t       p2_weak_up,
    // Synchronised pin levels to the core
    output qbp_byte_t       p0_level,
    output qbp_byte_t       p1_level,
    output qbp_byte_t       p2_level,
    output qbp_byte_t       muxed_addr_data_bus,
    // Second port alternate inputs
    output logic            timer2_ext_io,
    output logic            timer2_capture_reload_trigger,
    output logic            serial1_receive_in,
    output logic            ext_irq_rise_a,
    output logic            ext_irq_fall_a,
    output logic            ext_irq_rise_b,
    output logic            ext_irq_fall_b
);

    // All block state in one record, registered by a single process
    typedef struct packed {
        logic [7:0] p0_latch;
        logic [7:0] m0;
        logic [7:0] m2;
        logic [7:0] s1_0;
        logic [7:0] s1_1;
        logic [7:0] s1_2;
        logic [7:0] p0_out;
        logic [7:0] p0_oe;
        logic [7:0] p1_out;
        logic [7:0] p1_oe;
        logic [7:0] p2_out;
        logic [7:0] p2_oe;
        logic [7:0] lv0;
        logic [7:0] lv1;
        logic [7:0] lv2;
        logic [3:0] irq;
        logic       t2;
        logic       t2x;
        logic       rx;
    } qbp_top_state_t;

    qbp_top_state_t s_q;
    qbp_top_state_t s_d;
    qbp_byte_t      p1_alt_en, p1_alt_val;
    qbp_byte_t      p1_low, p1_kick, p1_weak;
    qbp_byte_t      p2_low, p2_kick, p2_weak;
    qbp_byte_t      p2_alt_en;
    qbp_byte_t      s1_new, s1_old;

    // Only timer and serial outputs override the second port latch
    always_comb
    begin
        p1_alt_en  = `QBP_ZERO;
        p1_alt_val = `QBP_ZERO;
        p1_alt_en[`QBP_B_T2_IO]   = timer2_out_en;
        p1_alt_val[`QBP_B_T2_IO]  = timer2_out;
        p1_alt_en[`QBP_B_SER_TX]  = serial1_transmit_en;
        p1_alt_val[`QBP_B_SER_TX] = serial1_transmit_out;
        // Bus mode hands the whole upper-address port to the address
        p2_alt_en = bus_active ? 8'hff : `QBP_ZERO;
    end

    // Both quasi ports share one module; the open-drain port is handled here
    qbp_quasi_port u_port1 (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .wr_en     (p1_wr),
        .wr_data   (wr_data),
        .alt_en    (p1_alt_en),
        .alt_val   (p1_alt_val),
        .latch     (),
        .pull_low  (p1_low),
        .kick_high (p1_kick),
        .weak_up   (p1_weak)
    );

    qbp_quasi_port u_port2 (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .wr_en     (p2_wr),
        .wr_data   (wr_data),
        .alt_en    (p2_alt_en),
        .alt_val   (upper_address_byte),
        .latch     (),
        .pull_low  (p2_low),
        .kick_high (p2_kick),
        .weak_up   (p2_weak)
    );

    // Every output is a state bit; weak pullup flags are registered in the port
    assign p0_pin_out          = s_q.p0_out;
    assign p0_pin_oe           = s_q.p0_oe;
    assign p1_pin_out          = s_q.p1_out;
    assign p1_pin_oe           = s_q.p1_oe;
    assign p2_pin_out          = s_q.p2_out;
    assign p2_pin_oe           = s_q.p2_oe;
    assign p1_weak_up          = p1_weak;
    assign p2_weak_up          = p2_weak;
    assign p0_level            = s_q.lv0;
    assign p1_level            = s_q.lv1;
    assign p2_level            = s_q.lv2;
    assign muxed_addr_data_bus = s_q.lv0;
    assign timer2_ext_io                 = s_q.t2;
    assign timer2_capture_reload_trigger = s_q.t2x;
    assign serial1_receive_in            = s_q.rx;
    assign ext_irq_rise_a      = s_q.irq[0];
    assign ext_irq_fall_a      = s_q.irq[1];
    assign ext_irq_rise_b      = s_q.irq[2];
    assign ext_irq_fall_b      = s_q.irq[3];

    always_comb
    begin
        s_d    = s_q;
        s1_new = s_q.s1_1;
        s1_old = s_q.s1_2;
        if (p0_wr)
        begin
            s_d.p0_latch = wr_data;
        end
        if (bus_active)
        begin
            // Bus mode drives both levels, address then data
            // Read cycles release the port so the memory can drive data
            s_d.p0_out = bus_addr_phase ? bus_addr_lo : bus_data_out;
            s_d.p0_oe  = (bus_addr_phase || bus_data_drive) ? 8'hff : `QBP_ZERO;
        end
        else
        begin
            // Open drain: only ever pulls low, never high
            s_d.p0_out = `QBP_ZERO;
            s_d.p0_oe  = ~s_d.p0_latch;
        end
        // Extra stage keeps every pin drive straight from a flop
        s_d.p1_out = p1_kick;
        s_d.p1_oe  = p1_low | p1_kick;
        s_d.p2_out = p2_kick;
        s_d.p2_oe  = p2_low | p2_kick;
        // Two-flop synchronisers on ports 0 and 2; port 1 level and alternate inputs pass three flops
        s_d.m0     = p0_pin_in;
        s_d.lv0    = s_q.m0;
        s_d.s1_0   = p1_pin_in;
        s_d.s1_1   = s_q.s1_0;
        s_d.s1_2   = s_q.s1_1;
        s_d.lv1    = s_q.s1_1;
        s_d.m2     = p2_pin_in;
        s_d.lv2    = s_q.m2;
        s_d.t2     = s1_new[`QBP_B_T2_IO];
        s_d.t2x    = s1_new[`QBP_B_T2_TRIG];
        s_d.rx     = s1_new[`QBP_B_SER_RX];
        // Third stage of port 1 only serves as the previous sample
        // Pulses last one cycle; a slower core must latch them itself
        s_d.irq[0] = s1_new[`QBP_B_IRQ_RISE_A] & ~s1_old[`QBP_B_IRQ_RISE_A];
        s_d.irq[2] = s1_new[`QBP_B_IRQ_RISE_B] & ~s1_old[`QBP_B_IRQ_RISE_B];
        s_d.irq[1] = ~s1_new[`QBP_B_IRQ_FALL_A] & s1_old[`QBP_B_IRQ_FALL_A];
        s_d.irq[3] = ~s1_new[`QBP_B_IRQ_FALL_B] & s1_old[`QBP_B_IRQ_FALL_B];
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            // Port 0 latch high leaves it undriven
            // Synchronisers start high like the pulled-up pins, so no false edge
            s_q <= '{p0_latch: `QBP_LATCH_RST, m0: `QBP_LATCH_RST, m2: `QBP_LATCH_RST,
                     s1_0: `QBP_LATCH_RST, s1_1: `QBP_LATCH_RST, s1_2: `QBP_LATCH_RST,
                     lv0: `QBP_LATCH_RST, lv1: `QBP_LATCH_RST, lv2: `QBP_LATCH_RST,
                     t2: 1'b1, t2x: 1'b1, rx: 1'b1, default: '0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

endmodule // qbp_ports

// ===== verif/qbp_ports_assertions.sv
`timescale 1ns/1ps
module qbp_ports_chk
    import qbp_pkg::*;
(
    // Clock and reset
    input wire logic      sys_clk,
    input wire logic      rst_b,
    // Core side
    input wire logic      p1_wr,
    input wire qbp_byte_t wr_data,
    input wire logic      bus_active,
    input wire logic      bus_addr_phase,
    input wire logic      bus_data_drive,
    input wire qbp_byte_t bus_addr_lo,
    // Pins and levels
    input wire qbp_byte_t p0_pin_out,
    input wire qbp_byte_t p0_pin_oe,
    input wire qbp_byte_t p1_pin_in,
    input wire qbp_byte_t p1_pin_out,
    input wire qbp_byte_t p1_pin_oe,
    input wire qbp_byte_t p1_weak_up,
    input wire qbp_byte_t p2_weak_up,
    input wire qbp_byte_t p1_level,
    input wire logic      serial1_receive_in,
    input wire logic      ext_irq_rise_a,
    input wire logic      ext_irq_fall_a
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    property p_rst_state;
        $rose(rst_b) |-> p0_pin_oe == 8'h00 && p1_weak_up == 8'hff && p2_weak_up == 8'hff;
    endproperty
    a_rst_state: assert property (p_rst_state) else $error("reset drive wrong");
    property p_pull;
        p1_wr && !wr_data[1] ##1 !p1_wr |-> ##1 (p1_pin_oe[1] && !p1_pin_out[1] && !p1_weak_up[1]);
    endproperty
    a_pull: assert property (p_pull) else $error("no pulldown after zero");
    property p_pull_hold;
        p1_pin_oe[1] && !p1_pin_out[1] && !p1_wr && !$past(p1_wr) |=> p1_pin_oe[1] && !p1_pin_out[1];
    endproperty
    a_pull_hold: assert property (p_pull_hold) else $error("pulldown dropped");
    property p_kick;
        (p1_pin_oe[1] && !p1_pin_out[1]) ##1 (p1_pin_oe[1] && p1_pin_out[1])
            |=> (p1_pin_oe[1] && p1_pin_out[1]) ##1 (!p1_pin_oe[1] && p1_weak_up[1]);
    endproperty
    a_kick: assert property (p_kick) else $error("kick length wrong");
    property p_od;
        (!bus_active)[*3] |-> (p0_pin_oe & p0_pin_out) == 8'h00;
    endproperty
    a_od: assert property (p_od) else $error("open drain drives high");
    property p_bus_addr;
        (bus_active && bus_addr_phase && !bus_data_drive)[*2] ##0 $stable(bus_addr_lo)
            |=> p0_pin_oe == 8'hff && p0_pin_out == $past(bus_addr_lo);
    endproperty
    a_bus_addr: assert property (p_bus_addr) else $error("address not driven");
    property p_irq_rise;
        $rose(p1_pin_in[4]) |-> ##[1:4] ext_irq_rise_a;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("rise irq missing");
    property p_irq_fall;
        $fell(p1_pin_in[5]) |-> ##[1:4] ext_irq_fall_a;
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("fall irq missing");
    property p_level;
        $stable(p1_pin_in)[*3] |-> p1_level == p1_pin_in && serial1_receive_in == p1_pin_in[2];
    endproperty
    a_level: assert property (p_level) else $error("level mismatch");

    c_kick: cover property ((p1_pin_oe[1] && !p1_pin_out[1]) ##1 (p1_pin_oe[1] && p1_pin_out[1]));
    c_irq: cover property (ext_irq_rise_a);
    c_bus: cover property (bus_active && bus_addr_phase);
endmodule // qbp_ports_chk

bind qbp_ports qbp_ports_chk u_chk (.*);

// ===== verif/qbp_pin_model.sv
`timescale 1ns/1ps
module qbp_pin_model
    import qbp_pkg::*;
(
    // Design drive
    input  wire qbp_byte_t oe,
    input  wire qbp_byte_t out,
    input  wire qbp_byte_t pull,
    // Outside driver
    input  wire qbp_byte_t ext_en,
    input  wire qbp_byte_t ext_val,
    // Resolved level
    output qbp_byte_t      pin
);
    // Strong drive wins; outside beats weak pull; unpulled float reads inverted
    assign pin = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pull | ~out));
endmodule // qbp_pin_model

// ===== verif/test_qbp_ports.sv
`timescale 1ns/1ps
`include "qbp_consts.svh"
module test_qbp_ports
    import qbp_pkg::*;
;
    logic      sys_clk, rst_b, p0_wr, p1_wr, p2_wr, bus_active, bus_addr_phase, bus_data_drive;
    logic      timer2_out_en, timer2_out, serial1_transmit_en, serial1_transmit_out;
    logic      timer2_ext_io, timer2_capture_reload_trigger, serial1_receive_in;
    logic      ext_irq_rise_a, ext_irq_fall_a, ext_irq_rise_b, ext_irq_fall_b;
    qbp_byte_t wr_data, bus_addr_lo, bus_data_out, upper_address_byte, ext_en, ext_val;
    qbp_byte_t p0_pin_in, p0_pin_out, p0_pin_oe, p1_pin_in, p1_pin_out, p1_pin_oe, p1_weak_up;
    qbp_byte_t p2_pin_in, p2_pin_out, p2_pin_oe, p2_weak_up, p0_level, p1_level, p2_level;
    qbp_byte_t muxed_addr_data_bus, oe_s, out_s, wk_s;
    logic [3:0] irq_v;
    int        n_mismatch, checks, sel;

    qbp_ports dut (.*);
    // Port 0 has its external resistor fitted
    qbp_pin_model m0 (.oe(p0_pin_oe), .out(p0_pin_out), .pull(8'hff), .ext_en(8'h00), .ext_val(8'h00),
                      .pin(p0_pin_in));
    qbp_pin_model m1 (.oe(p1_pin_oe), .out(p1_pin_out), .pull(p1_weak_up), .ext_en(ext_en),
                      .ext_val(ext_val), .pin(p1_pin_in));
    qbp_pin_model m2 (.oe(p2_pin_oe), .out(p2_pin_out), .pull(p2_weak_up), .ext_en(8'h00), .ext_val(8'h00),
                      .pin(p2_pin_in));

    assign irq_v = {ext_irq_fall_b, ext_irq_rise_b, ext_irq_fall_a, ext_irq_rise_a};
    always_comb
    begin
        oe_s = (sel == 1) ? p1_pin_oe : p2_pin_oe;
        out_s = (sel == 1) ? p1_pin_out : p2_pin_out;
        wk_s = (sel == 1) ? p1_weak_up : p2_weak_up;
    end

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic complete_run();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input qbp_byte_t got, input qbp_byte_t exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic wr(input int port, input qbp_byte_t d);
        wr_data = d;
        {p0_wr, p1_wr, p2_wr} = {port == 0, port == 1, port == 2};
        cyc(1);
        {p0_wr, p1_wr, p2_wr} = 3'h0;
    endtask

    task automatic sc_quasi(input int port);
        int k;
        sel = port;
        wr(port, 8'ha5);
        cyc(6);
        chk(oe_s & ~out_s, 8'h5a);
        chk(wk_s, 8'ha5);
        wr(port, 8'hff);
        k = 0;
        repeat (6)
        begin
            if ((oe_s & out_s) == 8'h5a)
                k++;
            cyc(1);
        end
        chk(8'(k), 8'(`QBP_KICK_CYC));
        chk(oe_s, 8'h00);
        chk(wk_s, 8'hff);
    endtask

    task automatic sc_input();
        {ext_en, ext_val} = {8'h07, 8'h00};
        {serial1_transmit_en, serial1_transmit_out} = 2'b10;
        cyc(6);
        chk({5'h00, serial1_receive_in, timer2_capture_reload_trigger, timer2_ext_io}, 8'h00);
        chk(p1_pin_oe & 8'h07, 8'h00);
        chk(p1_level, 8'hf0);
        chk(p1_pin_oe & ~p1_pin_out & 8'h08, 8'h08);
        {ext_en, serial1_transmit_en, timer2_out_en, timer2_out} = {8'h00, 3'b010};
        cyc(6);
        chk({5'h00, serial1_receive_in, timer2_capture_reload_trigger, timer2_ext_io}, 8'h06);
        chk(p1_pin_oe & ~p1_pin_out & 8'h01, 8'h01);
        timer2_out_en = 1'b0;
    endtask

    task automatic cnt(input int b, input logic lvl, input logic exp);
        qbp_byte_t n;
        n = 8'h00;
        {ext_en[b], ext_val[b]} = {1'b1, lvl};
        repeat (8)
        begin
            @(posedge sys_clk);
            #1;
            n = n + {7'h00, irq_v[b-4]};
        end
        chk(n, {7'h00, exp});
        @(negedge sys_clk);
    endtask

    task automatic sc_irq();
        for (int b = 4; b < 8; b++)
        begin
            cnt(b, 1'b0, b[0]);
            cnt(b, 1'b1, ~b[0]);
            ext_en[b] = 1'b0;
        end
    endtask

    task automatic sc_bus();
        {bus_active, bus_addr_phase, bus_addr_lo, upper_address_byte} = {2'b11, 8'h5a, 8'h3c};
        bus_data_out = 8'hc3;
        cyc(5);
        chk(p0_pin_oe, 8'hff);
        chk(muxed_addr_data_bus, 8'h5a);
        {bus_addr_phase, bus_data_drive} = 2'b01;
        cyc(5);
        chk(p0_pin_out, 8'hc3);
        chk(p2_pin_oe & ~p2_pin_out, 8'hc3);
        chk(p2_pin_in, 8'h3c);
        chk(p2_level, 8'h3c);
        {bus_active, bus_data_drive} = 2'b00;
        cyc(3);
        chk(p0_pin_oe, 8'h00);
        wr(0, 8'h0f);
        cyc(4);
        chk(p0_pin_oe, 8'hf0);
        chk(p0_pin_out, 8'h00);
        chk(p0_level, 8'h0f);
    endtask

    task automatic sc_reset();
        wr(1, 8'h00);
        cyc(8);
        chk(p1_pin_oe & ~p1_pin_out, 8'hff);
        rst_b = 1'b0;
        cyc(2);
        rst_b = 1'b1;
        cyc(2);
        chk(p1_pin_oe, 8'h00);
        chk(p1_weak_up & p1_level, 8'hff);
    endtask

    initial
    begin
        {rst_b, p0_wr, p1_wr, p2_wr, bus_active, bus_addr_phase, bus_data_drive} = 7'h00;
        {timer2_out_en, timer2_out, serial1_transmit_en, serial1_transmit_out} = 4'h0;
        {wr_data, bus_addr_lo, bus_data_out, upper_address_byte, ext_en, ext_val} = 48'h0;
        {n_mismatch, checks, sel} = {32'd0, 32'd0, 32'd1};
        cyc(2);
        rst_b = 1'b1;
        chk(p0_pin_oe, 8'h00);
        chk(p1_weak_up & p2_weak_up & ~p1_pin_oe & ~p2_pin_oe, 8'hff);
        sc_quasi(1);
        sc_quasi(2);
        sc_input();
        sc_irq();
        sc_bus();
        sc_reset();
        complete_run();
    end

    // Hang guard
    initial
    begin
        #200000;
        n_mismatch++;
        complete_run();
    end
endmodule // test_qbp_ports
